/* logic/tws_map.vh */
// register map, field positions, status codes and timing constants of the
// two-wire serial bus controller; definitions only
`ifndef TWS_MAP_VH
`define TWS_MAP_VH

// clock: 250 MHz, 4 ns
`define TWS_CLK_KHZ 250000
`define TWS_CLK_NS 4
// fastest bit period in ns (1 MHz)
`define TWS_MAX_BIT_NS 1000
// scl rates in kHz for rate codes 0..6; code 7 uses the timer overflow
`define TWS_KHZ_R0 100
`define TWS_KHZ_R1 200
`define TWS_KHZ_R2 400
`define TWS_KHZ_R3 600
`define TWS_KHZ_R4 800
`define TWS_KHZ_R5 (1000000 / `TWS_MAX_BIT_NS)
`define TWS_KHZ_R6 50
// quarter of an scl period in clock cycles, rounded down
`define TWS_QTR(khz) (`TWS_CLK_KHZ / (4 * (khz)))
`define TWS_RATE_TIMER 3'h7
// data hold after scl falls: 6 clocks
`define TWS_HD_DAT_CYC 3'h6
// recovery pulses
`define TWS_RCV_LAST 4'h8

// register offsets (byte addresses)
`define TWS_OFF_CTRL 8'h00
`define TWS_OFF_DATA 8'h04
`define TWS_OFF_ADR 8'h08
`define TWS_OFF_STS 8'h0C
`define TWS_OFF_INTC 8'h10

// control register fields
`define TWS_C_RATE_HI 2
`define TWS_C_RATE_LO 0
`define TWS_C_SI 3
`define TWS_C_AA 4
`define TWS_C_STO 5
`define TWS_C_STA 6
`define TWS_C_EN 7
`define TWS_C_RCV 8
// interrupt control register: irq enable bit
`define TWS_I_IEN 0
// status register: busy flag above the 8-bit code
`define TWS_S_BUSY 8

// master engine states
`define TWS_ST_IDLE 3'h0
`define TWS_ST_START 3'h1
`define TWS_ST_RUN 3'h2
`define TWS_ST_HOLD 3'h3
`define TWS_ST_STOP 3'h4
`define TWS_ST_RCV 3'h5

// status codes
`define TWS_SC_START 8'h08
`define TWS_SC_RSTART 8'h10
`define TWS_SC_AW_ACK 8'h18
`define TWS_SC_AW_NAK 8'h20
`define TWS_SC_TX_ACK 8'h28
`define TWS_SC_TX_NAK 8'h30
`define TWS_SC_ARB 8'h38
`define TWS_SC_AR_ACK 8'h40
`define TWS_SC_AR_NAK 8'h48
`define TWS_SC_RX_ACK 8'h50
`define TWS_SC_RX_NAK 8'h58
`define TWS_SC_SW_ACK 8'h60
`define TWS_SC_ARB_SW 8'h68
`define TWS_SC_SRX_ACK 8'h80
`define TWS_SC_SRX_NAK 8'h88
`define TWS_SC_SSTOP 8'hA0
`define TWS_SC_IDLE 8'hF8

`endif

/* logic/tws_ctrl.v */
// two-wire serial bus controller: master/slave engine with apb registers
// assumes scl/sda inputs synchronous to REF_CLK and open-drain pads outside
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ns
`include "tws_map.vh"

// Behaviour
// - interrupt output only when irq enable bit set
// - stop is sda rising while scl high
// - only master makes start/stop; busy tracking
// - address byte is 7 bits plus direction
// - repeated start plus new address keeps bus
// - 8-bit bytes, unlimited count, address first
// - bytes shifted most significant bit first
// - ninth clock carries acknowledge, master clocks it
// - transmitter releases sda, receiver pulls low
// - software selects whether receiver acknowledges
// - scl held low while pending interrupt set as master or as addressed slave
// - released high but seen low loses arbitration
// - unacknowledged address makes stop and abandons
// - master receiver withholds last acknowledge
// - three-bit rate field selects scl frequency
// - scl up to 1 MHz supported
// - rate seven uses timer overflow period
// - first quarter after a hold may shrink to one clock
// - nine scl pulses recover a stuck bus
// - lost arbitration, own write address reports 0x68
module tws_ctrl (
    input wire REF_CLK, // 250 MHz clock
    input wire SRST, // synchronous reset, high
    input wire CE, // clock enable, freezes all state when low
    input wire PSEL, // apb select
    input wire PENABLE, // apb access phase
    input wire PWRITE, // apb write
    input wire [7:0] PADDR, // apb byte address
    input wire [31:0] PWDATA, // apb write data
    output reg [31:0] PRDATA, // apb read data
    output wire PREADY, // apb ready
    output reg PSLVERR, // apb error on unmapped address
    input wire SCL_I, // scl level on the bus
    output wire SCL_O, // scl output value, always low
    output reg SCL_OE, // scl pulled low while high
    input wire SDA_I, // sda level on the bus
    output wire SDA_O, // sda output value, always low
    output reg SDA_OE, // sda pulled low while high
    input wire TMR_OVF, // timer overflow pulse for rate seven
    output wire IRQ // interrupt request, high
);

    localparam integer QTR_R0 = `TWS_QTR(`TWS_KHZ_R0);
    localparam integer QTR_R1 = `TWS_QTR(`TWS_KHZ_R1);
    localparam integer QTR_R2 = `TWS_QTR(`TWS_KHZ_R2);
    localparam integer QTR_R3 = `TWS_QTR(`TWS_KHZ_R3);
    localparam integer QTR_R4 = `TWS_QTR(`TWS_KHZ_R4);
    localparam integer QTR_R5 = `TWS_QTR(`TWS_KHZ_R5);
    localparam integer QTR_R6 = `TWS_QTR(`TWS_KHZ_R6);

    // quarter scl period for a rate code
    function [15:0] qtr_len;
        input [2:0] r;
        begin
            case (r)
                3'h0: qtr_len = QTR_R0[15:0];
                3'h1: qtr_len = QTR_R1[15:0];
                3'h2: qtr_len = QTR_R2[15:0];
                3'h3: qtr_len = QTR_R3[15:0];
                3'h4: qtr_len = QTR_R4[15:0];
                3'h5: qtr_len = QTR_R5[15:0];
                default: qtr_len = QTR_R6[15:0];
            endcase
        end
    endfunction

    // data bit n of a byte, msb first
    function bit_of;
        input [7:0] d;
        input [3:0] n;
        begin
            bit_of = d[3'h7 - n[2:0]];
        end
    endfunction

    reg [8:0] ctrl_q;
    reg [7:0] data_q;
    reg [7:0] own_adr_q;
    reg [7:0] sts_q;
    reg ien_q;
    reg si_q;
    reg [2:0] st_q;
    reg [1:0] qph_q;
    reg [15:0] qcnt_q;
    reg tdiv_q;
    reg own_q;
    reg arb_q;
    reg tx_q;
    reg slv_q;
    reg bus_addr_q;
    reg [3:0] bitcnt_q;
    reg [7:0] shr_q;
    reg ackb_q;
    reg scl_p_q;
    reg sda_p_q;
    reg busy_q;
    reg free_pend_q;
    reg [2:0] hd_cnt_q;
    reg [3:0] rcv_cnt_q;
    reg mst_scl_low;
    reg rel_phase;
    reg sda_oe_d;

    wire [2:0] rate = ctrl_q[`TWS_C_RATE_HI:`TWS_C_RATE_LO];
    wire en = ctrl_q[`TWS_C_EN];
    wire aa = ctrl_q[`TWS_C_AA];
    wire scl_rise = SCL_I & ~scl_p_q;
    wire scl_fall = ~SCL_I & scl_p_q;
    wire bus_start = SCL_I & scl_p_q & sda_p_q & ~SDA_I;
    wire bus_stop = SCL_I & scl_p_q & ~sda_p_q & SDA_I;
    wire timer_mode = (rate == `TWS_RATE_TIMER);
    wire qtr_tick = timer_mode ? (TMR_OVF & tdiv_q) :
        (qcnt_q == qtr_len(rate) - 16'h0001);
    wire stall = rel_phase & ~SCL_I;
    wire tick = qtr_tick & ~stall;
    wire data_ph = (bitcnt_q < 4'h8);
    wire addr_match = (shr_q[7:1] == own_adr_q[7:1]);
    wire match_wr = bus_addr_q & addr_match & ~shr_q[0];
    wire ack_seen = ~ackb_q;
    wire lose = busy_q & scl_rise & own_q & tx_q & data_ph & (st_q == `TWS_ST_RUN) &
        ~SDA_OE & ~SDA_I;
    wire apb_wr = PSEL & PENABLE & PWRITE;
    wire want_low = data_ph ? (own_q & tx_q & ~bit_of(data_q, bitcnt_q)) :
        (~tx_q & aa & (own_q | slv_q | match_wr));
    wire scl_oe_d = en & (mst_scl_low | (slv_q & si_q));

    assign SCL_O = 1'b0;
    assign SDA_O = 1'b0;
    assign PREADY = CE;
    assign IRQ = si_q & ien_q;

    // master pin drive per state and quarter
    always @* begin
        mst_scl_low = 1'b0;
        rel_phase = 1'b0;
        case (st_q)
            `TWS_ST_START: begin
                mst_scl_low = (qph_q == 2'h0) ? own_q : (qph_q == 2'h3);
                rel_phase = (qph_q == 2'h1) | (qph_q == 2'h2);
            end
            `TWS_ST_RUN, `TWS_ST_RCV: begin
                mst_scl_low = ~qph_q[1];
                rel_phase = qph_q[1];
            end
            `TWS_ST_HOLD: mst_scl_low = 1'b1;
            `TWS_ST_STOP: begin
                mst_scl_low = (qph_q == 2'h0);
                rel_phase = (qph_q != 2'h0);
            end
            default: begin
                mst_scl_low = 1'b0;
                rel_phase = 1'b0;
            end
        endcase
    end

    // sda drive: forced during start/stop, released during recovery, else updated while scl low
    always @* begin
        sda_oe_d = SDA_OE;
        if (!en || lose) begin
            sda_oe_d = 1'b0;
        end else if (st_q == `TWS_ST_START) begin
            sda_oe_d = qph_q[1];
        end else if (st_q == `TWS_ST_STOP) begin
            sda_oe_d = ~qph_q[1];
        end else if (st_q == `TWS_ST_RCV) begin
            sda_oe_d = 1'b0;
        end else if (!SCL_I && hd_cnt_q == `TWS_HD_DAT_CYC) begin
            sda_oe_d = want_low;
        end
    end

    always @(posedge REF_CLK) begin
        if (SRST) begin
            ctrl_q <= 9'h000;
            data_q <= 8'h00;
            own_adr_q <= 8'h00;
            sts_q <= `TWS_SC_IDLE;
            ien_q <= 1'b0;
            si_q <= 1'b0;
            st_q <= `TWS_ST_IDLE;
            qph_q <= 2'h0;
            qcnt_q <= 16'h0000;
            tdiv_q <= 1'b0;
            own_q <= 1'b0;
            arb_q <= 1'b0;
            tx_q <= 1'b0;
            slv_q <= 1'b0;
            bus_addr_q <= 1'b0;
            bitcnt_q <= 4'h0;
            shr_q <= 8'h00;
            ackb_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            busy_q <= 1'b0;
            free_pend_q <= 1'b0;
            hd_cnt_q <= 3'h0;
            rcv_cnt_q <= 4'h0;
            PRDATA <= 32'h00000000;
            PSLVERR <= 1'b0;
            SCL_OE <= 1'b0;
            SDA_OE <= 1'b0;
        end else if (CE) begin
            // apb: read data latched in the setup cycle, writes in access
            if (PSEL && !PENABLE) begin
                PSLVERR <= 1'b0;
                case (PADDR)
                    `TWS_OFF_CTRL: PRDATA <= {23'h000000, ctrl_q[8:4], si_q, ctrl_q[2:0]};
                    `TWS_OFF_DATA: PRDATA <= {24'h000000, data_q};
                    `TWS_OFF_ADR: PRDATA <= {24'h000000, own_adr_q[7:1], 1'b0};
                    `TWS_OFF_STS: PRDATA <= {23'h000000, busy_q, sts_q};
                    `TWS_OFF_INTC: PRDATA <= {31'h00000000, ien_q};
                    default: begin
                        PRDATA <= 32'h00000000;
                        PSLVERR <= 1'b1;
                    end
                endcase
            end
            if (apb_wr) begin
                case (PADDR)
                    `TWS_OFF_CTRL: begin
                        ctrl_q <= {PWDATA[8:4], 1'b0, PWDATA[2:0]};
                        if (PWDATA[`TWS_C_SI]) begin
                            si_q <= 1'b0;
                        end
                    end
                    `TWS_OFF_DATA: data_q <= PWDATA[7:0];
                    `TWS_OFF_ADR: own_adr_q <= {PWDATA[7:1], 1'b0};
                    `TWS_OFF_INTC: ien_q <= PWDATA[`TWS_I_IEN];
                    default: ;
                endcase
            end

            // bus observer
            scl_p_q <= SCL_I;
            sda_p_q <= SDA_I;
            SCL_OE <= scl_oe_d;
            SDA_OE <= sda_oe_d;
            if (SCL_I) begin
                hd_cnt_q <= 3'h0;
            end else if (hd_cnt_q != `TWS_HD_DAT_CYC) begin
                hd_cnt_q <= hd_cnt_q + 3'h1;
            end
            if (TMR_OVF) begin
                tdiv_q <= ~tdiv_q;
            end
            // idle keeps counting while a seen stop waits to free the bus
            if (qtr_tick || stall || (st_q == `TWS_ST_IDLE && !free_pend_q)) begin
                qcnt_q <= 16'h0000;
            end else begin
                qcnt_q <= qcnt_q + 16'h0001;
            end
            if (bus_start) begin
                busy_q <= 1'b1;
                free_pend_q <= 1'b0;
            end else if (bus_stop) begin
                free_pend_q <= 1'b1;
            end else if (free_pend_q && qtr_tick) begin
                busy_q <= 1'b0;
                free_pend_q <= 1'b0;
            end

            // master engine
            if (tick) begin
                qph_q <= qph_q + 2'h1;
            end
            case (st_q)
                `TWS_ST_IDLE: begin
                    qph_q <= 2'h0;
                    if (en && ctrl_q[`TWS_C_RCV] && !busy_q) begin
                        st_q <= `TWS_ST_RCV;
                    end else if (en && ctrl_q[`TWS_C_STA] && !busy_q) begin
                        st_q <= `TWS_ST_START;
                    end
                end
                `TWS_ST_START: begin
                    if (tick && qph_q == 2'h3) begin
                        sts_q <= own_q ? `TWS_SC_RSTART : `TWS_SC_START;
                        si_q <= 1'b1;
                        own_q <= 1'b1;
                        tx_q <= 1'b1;
                        ctrl_q[`TWS_C_STA] <= 1'b0;
                        st_q <= `TWS_ST_HOLD;
                    end
                end
                `TWS_ST_HOLD: begin
                    qph_q <= 2'h0;
                    if (!si_q) begin
                        if (ctrl_q[`TWS_C_STO]) begin
                            st_q <= `TWS_ST_STOP;
                        end else if (ctrl_q[`TWS_C_STA]) begin
                            st_q <= `TWS_ST_START;
                        end else begin
                            st_q <= `TWS_ST_RUN;
                        end
                    end
                end
                `TWS_ST_STOP: begin
                    if (tick && qph_q == 2'h3) begin
                        own_q <= 1'b0;
                        ctrl_q[`TWS_C_STO] <= 1'b0;
                        sts_q <= `TWS_SC_IDLE;
                        st_q <= `TWS_ST_IDLE;
                    end
                end
                `TWS_ST_RCV: begin
                    if (tick && qph_q == 2'h3) begin
                        if (rcv_cnt_q == `TWS_RCV_LAST) begin
                            rcv_cnt_q <= 4'h0;
                            ctrl_q[`TWS_C_RCV] <= 1'b0;
                            st_q <= `TWS_ST_IDLE;
                        end else begin
                            rcv_cnt_q <= rcv_cnt_q + 4'h1;
                        end
                    end
                end
                `TWS_ST_RUN: ;
                default: st_q <= `TWS_ST_IDLE;
            endcase

            // bit and byte framing on bus edges
            if (bus_start || bus_stop) begin
                bitcnt_q <= 4'h0;
                bus_addr_q <= bus_start;
                if (slv_q) begin
                    slv_q <= 1'b0;
                    sts_q <= `TWS_SC_SSTOP;
                    si_q <= 1'b1;
                end
            end else if (busy_q && scl_rise) begin
                if (data_ph) begin
                    shr_q <= {shr_q[6:0], SDA_I};
                end else begin
                    ackb_q <= SDA_I;
                end
                bitcnt_q <= bitcnt_q + 4'h1;
                if (lose) begin
                    own_q <= 1'b0;
                    arb_q <= 1'b1;
                    tx_q <= 1'b0;
                    st_q <= `TWS_ST_IDLE;
                end
            end else if (busy_q && scl_fall && bitcnt_q == 4'h9) begin
                bitcnt_q <= 4'h0;
                bus_addr_q <= 1'b0;
                if (own_q) begin
                    si_q <= 1'b1;
                    st_q <= `TWS_ST_HOLD;
                    if (bus_addr_q) begin
                        tx_q <= ~shr_q[0];
                        if (shr_q[0]) begin
                            sts_q <= ack_seen ? `TWS_SC_AR_ACK : `TWS_SC_AR_NAK;
                        end else begin
                            sts_q <= ack_seen ? `TWS_SC_AW_ACK : `TWS_SC_AW_NAK;
                        end
                        if (!ack_seen) begin
                            ctrl_q[`TWS_C_STO] <= 1'b1;
                        end
                    end else if (tx_q) begin
                        sts_q <= ack_seen ? `TWS_SC_TX_ACK : `TWS_SC_TX_NAK;
                    end else begin
                        data_q <= shr_q;
                        sts_q <= ack_seen ? `TWS_SC_RX_ACK : `TWS_SC_RX_NAK;
                    end
                end else if (arb_q) begin
                    arb_q <= 1'b0;
                    si_q <= 1'b1;
                    if (match_wr && ack_seen) begin
                        slv_q <= 1'b1;
                        sts_q <= `TWS_SC_ARB_SW;
                    end else begin
                        sts_q <= `TWS_SC_ARB;
                    end
                end else if (match_wr && ack_seen) begin
                    slv_q <= 1'b1;
                    si_q <= 1'b1;
                    sts_q <= `TWS_SC_SW_ACK;
                end else if (slv_q) begin
                    data_q <= shr_q;
                    si_q <= 1'b1;
                    sts_q <= ack_seen ? `TWS_SC_SRX_ACK : `TWS_SC_SRX_NAK;
                    if (!ack_seen) begin
                        slv_q <= 1'b0;
                    end
                end
            end

            if (!en) begin
                st_q <= `TWS_ST_IDLE;
                own_q <= 1'b0;
                slv_q <= 1'b0;
                arb_q <= 1'b0;
            end
        end
    end

endmodule // tws_ctrl

/* sim/tws_ctrl_sva.sv */
// checker for tws_ctrl: framing, scl timing, clock stretch and irq gating
// bound to tws_ctrl; follows register writes itself from the apb ports
`timescale 1ns/1ns
`include "tws_map.vh"
module tws_ctrl_sva (
    input wire REF_CLK, // clock
    input wire SRST, // reset
    input wire PSEL, // apb select
    input wire PENABLE, // apb access
    input wire PWRITE, // apb write
    input wire [7:0] PADDR, // apb address
    input wire [31:0] PWDATA, // apb write data
    input wire PREADY, // apb ready
    input wire SCL_I, // scl level
    input wire SDA_I, // sda level
    input wire SCL_OE, // scl pulled low
    input wire SDA_OE, // sda pulled low
    input wire IRQ // interrupt
);
    reg ien_q, en_q, scl_q, sda_q, st_q, bsy_q;
    reg [2:0] rate_q;
    reg [3:0] edge_q;
    reg [11:0] hi_q;
    int qtr;
    wire wr_any = PSEL && PENABLE && PWRITE && PREADY;
    wire wr_ctrl = wr_any && PADDR == `TWS_OFF_CTRL;
    wire start_c = SCL_I && scl_q && sda_q && !SDA_I;
    wire stop_c = SCL_I && scl_q && !sda_q && SDA_I;
    always @* begin
        case (rate_q)
            3'h0: qtr = `TWS_QTR(`TWS_KHZ_R0);
            3'h1: qtr = `TWS_QTR(`TWS_KHZ_R1);
            3'h2: qtr = `TWS_QTR(`TWS_KHZ_R2);
            3'h3: qtr = `TWS_QTR(`TWS_KHZ_R3);
            3'h4: qtr = `TWS_QTR(`TWS_KHZ_R4);
            3'h5: qtr = `TWS_QTR(`TWS_KHZ_R5);
            default: qtr = `TWS_QTR(`TWS_KHZ_R6);
        endcase
    end
    always @(posedge REF_CLK) begin
        scl_q <= SCL_I;
        sda_q <= SDA_I;
        if (SRST) begin
            ien_q <= 1'b0;
            en_q <= 1'b0;
            rate_q <= 3'h0;
            st_q <= 1'b0;
            bsy_q <= 1'b0;
        end else begin
            if (wr_any && PADDR == `TWS_OFF_INTC)
                ien_q <= PWDATA[`TWS_I_IEN];
            if (wr_ctrl)
                en_q <= PWDATA[`TWS_C_EN];
            if (wr_ctrl)
                rate_q <= PWDATA[2:0];
            st_q <= start_c || (st_q && SCL_I);
            bsy_q <= start_c || (bsy_q && !stop_c);
        end
        // scl rising edges since the last start or since the interrupt output was last high
        if (SRST || IRQ || start_c)
            edge_q <= 4'h0;
        else if (SCL_I && !scl_q)
            edge_q <= edge_q + 4'h1;
        hi_q <= !SCL_I ? 12'h000 : (hi_q == 12'hFFF ? hi_q : hi_q + 12'h001);
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    sequence s_start;
        SCL_I && !SCL_OE && $rose(SDA_OE) && rate_q <= 3'h5;
    endsequence
    sequence s_stop;
        SCL_I && $fell(SDA_OE);
    endsequence
    sequence s_fall;
        !SCL_I && scl_q && bsy_q && !st_q && rate_q <= 3'h5;
    endsequence
    property p_irq_gate;
        IRQ |-> ien_q;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");
    property p_hold;
        IRQ |-> SCL_OE;
    endproperty
    a_hold: assert property (p_hold) else $error("scl not held while pending");
    property p_release;
        wr_ctrl && PWDATA[`TWS_C_SI] && IRQ && rate_q != 3'h0 && rate_q <= 3'h5
            |-> ##[1:700] !SCL_OE;
    endproperty
    a_release: assert property (p_release) else $error("scl not released");
    property p_clk_count;
        $rose(IRQ) |-> edge_q == 4'h0 || edge_q == 4'h9;
    endproperty
    a_clk_count: assert property (p_clk_count) else $error("byte not nine clocks");
    property p_stop;
        s_stop |=> !SCL_OE [*8];
    endproperty
    a_stop: assert property (p_stop) else $error("scl driven after stop");
    property p_start;
        s_start |-> ##[1:700] SCL_OE;
    endproperty
    a_start: assert property (p_start) else $error("start not followed by scl low");
    property p_quiet;
        !en_q ##1 !en_q |-> !SCL_OE && !SDA_OE;
    endproperty
    a_quiet: assert property (p_quiet) else $error("bus driven while disabled");
    property p_scl_high;
        s_fall |-> hi_q + 4 >= 2 * qtr && hi_q <= 2 * qtr + 8;
    endproperty
    a_scl_high: assert property (p_scl_high) else $error("scl high time");
endmodule // tws_ctrl_sva

bind tws_ctrl tws_ctrl_sva u_sva (.REF_CLK(REF_CLK), .SRST(SRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
    .SCL_I(SCL_I), .SDA_I(SDA_I), .SCL_OE(SCL_OE), .SDA_OE(SDA_OE), .IRQ(IRQ));

/* sim/tws_slave_model.sv */
// slave receiver on the two-wire bus: acks its own address and every data byte
// sees resolved scl/sda levels with pull-ups; only pulls sda low
`timescale 1ns/1ns
module tws_slave_model #(
    parameter [6:0] OWN_ADDR = 7'h2A // own address
) (
    input wire clk, // bench clock
    input wire rst, // reset
    input wire scl, // scl level
    input wire sda, // sda level
    output reg sda_oe, // pulls sda low
    output reg [7:0] last_byte, // last byte taken
    output reg [7:0] byte_cnt // bytes since start
);
    reg scl_q, sda_q, act, ack_ph;
    reg [3:0] bit_n;
    reg [7:0] sh;
    always @(posedge clk) begin
        scl_q <= scl;
        sda_q <= sda;
        if (rst || (scl && scl_q && sda_q && !sda)) begin
            act <= !rst;
            bit_n <= 4'h0;
            byte_cnt <= 8'h00;
            ack_ph <= 1'b0;
            sda_oe <= 1'b0;
        end else if (scl && scl_q && !sda_q && sda) begin
            act <= 1'b0;
        end else if (act && scl && !scl_q && !ack_ph) begin
            sh <= {sh[6:0], sda};
            bit_n <= bit_n + 4'h1;
        end else if (act && !scl && scl_q && ack_ph) begin
            sda_oe <= 1'b0;
            ack_ph <= 1'b0;
            bit_n <= 4'h0;
        end else if (act && !scl && scl_q && bit_n == 4'h8) begin
            ack_ph <= 1'b1;
            last_byte <= sh;
            byte_cnt <= byte_cnt + 8'h01;
            sda_oe <= byte_cnt != 8'h00 || sh[7:1] == OWN_ADDR;
            act <= byte_cnt != 8'h00 || sh[7:1] == OWN_ADDR;
        end
    end
endmodule // tws_slave_model

/* sim/tws_ctrl_tb.sv */
// bench for tws_ctrl: apb register sequences against a slave model
// bus lines are wired-and with pull-ups, resolved here
`timescale 1ns/1ns
`include "tws_map.vh"
module tws_ctrl_tb;
    reg REF_CLK, SRST, PSEL, PENABLE, PWRITE, err, scl_d, tmr;
    reg [7:0] PADDR;
    reg [31:0] PWDATA, rd, r0;
    wire [31:0] PRDATA;
    wire PREADY, PSLVERR, SCL_OE, SDA_OE, IRQ, slv_oe, scl_o, sda_o;
    wire [7:0] slv_byte, slv_cnt;
    wire scl_bus = !SCL_OE;
    wire sda_bus = !(SDA_OE || slv_oe);
    integer err_total, samples_checked, rises, i;
    tws_ctrl dut (.REF_CLK(REF_CLK), .SRST(SRST), .CE(1'b1), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SCL_I(scl_bus),
        .SCL_O(scl_o), .SCL_OE(SCL_OE), .SDA_I(sda_bus), .SDA_O(sda_o), .SDA_OE(SDA_OE),
        .TMR_OVF(tmr), .IRQ(IRQ));
    tws_slave_model #(.OWN_ADDR(7'h2A)) slv (.clk(REF_CLK), .rst(SRST), .scl(scl_bus),
        .sda(sda_bus), .sda_oe(slv_oe), .last_byte(slv_byte), .byte_cnt(slv_cnt));
    initial begin
        REF_CLK = 1'b0;
        forever #2 REF_CLK = ~REF_CLK;
    end
    always @(posedge REF_CLK) begin
        scl_d <= scl_bus;
        // timer overflow every other clock: a rate-seven quarter is four clocks
        tmr <= !tmr;
        if (scl_bus && !scl_d)
            rises <= rises + 1;
    end
    task check(input string name, input [31:0] exp, input [31:0] got);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            $display("mismatch %0s expected %h seen %h", name, exp, got);
            err_total = err_total + 1;
        end
    endtask
    task apb(input wr, input [7:0] a, input [31:0] d);
        @(posedge REF_CLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        @(posedge REF_CLK);
        while (PREADY !== 1'b1)
            @(posedge REF_CLK);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task poll(input [7:0] a, input [31:0] m, input [31:0] v);
        i = 0;
        rd = ~v;
        while ((rd & m) !== v && i < 2000) begin
            apb(1'b0, a, 32'h0);
            i = i + 1;
        end
        check("poll", v, rd & m);
    endtask
    task wait_irq;
        i = 0;
        // let a pending clear issued at this edge take effect first
        @(posedge REF_CLK);
        while (IRQ !== 1'b1 && i < 20000) begin
            @(posedge REF_CLK);
            i = i + 1;
        end
        check("irq", 32'h1, IRQ);
    endtask
    // data is loaded before the pending flag is cleared
    task xfer(input [31:0] d, input [31:0] c, input [31:0] s);
        apb(1'b1, `TWS_OFF_DATA, d);
        apb(1'b1, `TWS_OFF_CTRL, c);
        wait_irq;
        apb(1'b0, `TWS_OFF_STS, 32'h0);
        check("status", s, rd);
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #300000;
        err_total = err_total + 1;
        print_verdict;
    end
    initial begin
        SRST = 1'b1;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        scl_d = 1'b1;
        tmr = 1'b0;
        rises = 0;
        err_total = 0;
        samples_checked = 0;
        repeat (2) @(posedge REF_CLK);
        SRST <= 1'b0;
        apb(1'b0, `TWS_OFF_STS, 32'h0);
        check("status reset", 32'h0F8, rd);
        apb(1'b0, `TWS_OFF_INTC, 32'h0);
        check("intc reset", 32'h0, rd);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped", 32'h1, {rd[30:0], err});
        apb(1'b1, `TWS_OFF_CTRL, 32'hC5);
        poll(`TWS_OFF_CTRL, 32'h8, 32'h8);
        check("irq masked", 32'h0, IRQ);
        apb(1'b0, `TWS_OFF_STS, 32'h0);
        check("start status", 32'h108, rd);
        apb(1'b1, `TWS_OFF_INTC, 32'h1);
        @(negedge REF_CLK);
        check("irq unmasked", 32'h1, IRQ);
        xfer(32'h54, 32'h8D, 32'h118);
        check("addr byte", 32'h54, slv_byte);
        xfer(32'hA5, 32'h8D, 32'h128);
        check("data byte", 32'hA5, slv_byte);
        xfer(32'h3C, 32'h8D, 32'h128);
        check("byte count", 32'h3, slv_cnt);
        apb(1'b1, `TWS_OFF_CTRL, 32'hCD);
        wait_irq;
        apb(1'b0, `TWS_OFF_STS, 32'h0);
        check("rep start", 32'h110, rd);
        xfer(32'h54, 32'h8D, 32'h118);
        check("count after rep", 32'h1, slv_cnt);
        apb(1'b1, `TWS_OFF_CTRL, 32'hAD);
        poll(`TWS_OFF_STS, 32'h1FF, 32'hF8);
        check("bus idle", 32'h3, {scl_bus, sda_bus});
        check("pad out", 32'h0, {scl_o, sda_o});
        apb(1'b1, `TWS_OFF_CTRL, 32'hC2);
        wait_irq;
        xfer(32'h22, 32'h8A, 32'h120);
        apb(1'b0, `TWS_OFF_CTRL, 32'h0);
        check("auto stop", 32'hAA, rd);
        apb(1'b1, `TWS_OFF_CTRL, 32'hAA);
        poll(`TWS_OFF_STS, 32'h1FF, 32'hF8);
        check("irq cleared", 32'h0, IRQ);
        r0 = rises;
        apb(1'b1, `TWS_OFF_CTRL, 32'h187);
        poll(`TWS_OFF_CTRL, 32'h100, 32'h0);
        check("recovery pulses", 32'h9, rises - r0);
        print_verdict;
    end
endmodule // tws_ctrl_tb
